/* hw/irqmp_pkg.sv */
package irqmp_pkg;

  // ==========================================================================
  // Register offsets (byte addresses on the 12-bit register port).
  // ==========================================================================
  localparam logic [11:0] OFS_MAIN_STATUS   = 12'h000;
  localparam logic [11:0] OFS_MAIN_UNMASKED = 12'h004;
  localparam logic [11:0] OFS_MAIN_EN_SET   = 12'h008;
  localparam logic [11:0] OFS_MAIN_EN_CLR   = 12'h00c;
  localparam logic [11:0] OFS_SOFT_REQ      = 12'h010;
  localparam logic [11:0] OFS_GRP_STATUS    = 12'h020;
  localparam logic [11:0] OFS_GRP_UNMASKED  = 12'h024;
  localparam logic [11:0] OFS_GRP_EN_SET    = 12'h028;
  localparam logic [11:0] OFS_GRP_EN_CLR    = 12'h02c;
  localparam logic [11:0] OFS_PRIO_BASE     = 12'h040;
  localparam logic [11:0] OFS_REQ_NUMBER    = 12'h050;
  localparam logic [11:0] OFS_THRESHOLD     = 12'h054;
  localparam logic [11:0] OFS_TRIG_MODE     = 12'h080;
  localparam logic [11:0] OFS_TRIG_POL      = 12'h084;
  localparam logic [11:0] OFS_EDGE_CLR      = 12'h088;
  localparam logic [11:0] OFS_GRP_TRIG_MODE = 12'h0a0;
  localparam logic [11:0] OFS_GRP_TRIG_POL  = 12'h0a4;
  localparam logic [11:0] OFS_GRP_EDGE_CLR  = 12'h0a8;

  // ==========================================================================
  // Field layout and sizes.
  // ==========================================================================
  localparam int          NUM_SRC       = 32;
  localparam int          NUM_GRP       = 8;
  localparam int          PRIO_W        = 2;
  localparam int          PRIO_NIBBLE   = 4;
  localparam int          PRIO_PER_REG  = 8;
  localparam int          SOFT_REQ_BIT  = 1;
  localparam int          THR_W         = 4;

  // ==========================================================================
  // Reset values and special codes.
  // ==========================================================================
  localparam logic [31:0] RST_MAIN_POL  = 32'hffff_ffff;
  localparam logic [7:0]  RST_GRP_POL   = 8'hff;
  localparam logic [3:0]  RST_THRESHOLD = 4'hf;
  localparam logic [3:0]  THR_NONE      = 4'hf;
  localparam logic [15:0] RST_REQ_NUM   = 16'hffff;
  localparam logic [7:0]  NONE_PENDING  = 8'hff;

endpackage

/* hw/irqmp_prio_mem.sv */
`timescale 1ns/1ps

// Holds the 32 two-bit source priorities, packed eight per word.
module irqmp_prio_mem (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        we,
  input  wire logic [1:0]  idx,
  input  wire logic [31:0] wdata,
  output logic      [63:0] fields
);

  // ==========================================================================
  // Storage.
  // ==========================================================================
  // Only the low two bits of each nibble are stored; the rest read as zero.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fields <= 64'h0;
    end else if (we) begin
      for (int k = 0; k < irqmp_pkg::PRIO_PER_REG; k++) begin
        fields[idx*16 + k*2 +: 2] <= wdata[k*irqmp_pkg::PRIO_NIBBLE +: irqmp_pkg::PRIO_W];
      end
    end
  end

endmodule

/* hw/irqmp_ctrl.sv */
`timescale 1ns/1ps

// ============================================================================
// ============================================================================
module irqmp_ctrl (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [11:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  input  wire logic [31:0] src_request_lines,
  input  wire logic [7:0]  group_request_inputs,
  output logic             core_irq
);

  // ==========================================================================
  // Helper functions.
  // ==========================================================================
  // True when a priority clears the threshold; 0xf sits below level zero.
  function automatic logic above_thr(input logic [1:0] p, input logic [3:0] t);
    if (t == irqmp_pkg::THR_NONE) begin
      return 1'b1;
    end
    return {2'b00, p} > t;
  endfunction

  // The four priority words sit on aligned offsets just above the priority base.
  function automatic logic prio_hit(input logic [11:0] a);
    return a[11:4] == irqmp_pkg::OFS_PRIO_BASE[11:4] && a[1:0] == 2'b00;
  endfunction

  // Highest priority pending source, lowest number wins a tie.
  function automatic logic [15:0] pick(input logic [31:0] pend, input logic [63:0] pf);
    logic [15:0] res;
    logic        found;
    logic [1:0]  best;
    res   = {irqmp_pkg::NONE_PENDING, irqmp_pkg::NONE_PENDING};
    found = 1'b0;
    best  = 2'b00;
    // Walking downward with >= lets a lower number take over an equal level.
    for (int i = irqmp_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (pend[i] && (!found || pf[i*2 +: 2] >= best)) begin
        found = 1'b1;
        best  = pf[i*2 +: 2];
        res   = {6'h00, pf[i*2 +: 2], 8'(i)};
      end
    end
    return res;
  endfunction

  // Decodes which offsets answer a read with data.
  function automatic logic mapped(input logic [11:0] a);
    case (a)
      irqmp_pkg::OFS_MAIN_STATUS, irqmp_pkg::OFS_MAIN_UNMASKED, irqmp_pkg::OFS_MAIN_EN_SET,
      irqmp_pkg::OFS_GRP_STATUS, irqmp_pkg::OFS_GRP_UNMASKED, irqmp_pkg::OFS_GRP_EN_SET,
      irqmp_pkg::OFS_REQ_NUMBER, irqmp_pkg::OFS_THRESHOLD, irqmp_pkg::OFS_TRIG_MODE,
      irqmp_pkg::OFS_TRIG_POL, irqmp_pkg::OFS_GRP_TRIG_MODE, irqmp_pkg::OFS_GRP_TRIG_POL: return 1'b1;
      default: return prio_hit(a);
    endcase
  endfunction

  // ==========================================================================
  // State.
  // ==========================================================================
  logic [31:0] en_q;
  logic [7:0]  gen_q;
  logic [31:0] mode_q;
  logic [31:0] pol_q;
  logic [7:0]  gmode_q;
  logic [7:0]  gpol_q;
  logic [31:0] lat_q;
  logic [31:0] lat_d;
  logic [7:0]  glat_q;
  logic [7:0]  glat_d;
  logic [31:0] prev_q;
  logic [7:0]  gprev_q;
  logic        soft_q;
  logic [3:0]  thr_q;
  logic [15:0] reqnum_q;
  logic [63:0] prio_f;

  // ==========================================================================
  // Write decode.
  // ==========================================================================
  logic wr_en_set;
  logic wr_en_clr;
  logic wr_gen_set;
  logic wr_gen_clr;
  logic wr_prio;
  logic [31:0] main_clr;
  logic [7:0]  grp_clr;

  assign wr_en_set  = wr && addr == irqmp_pkg::OFS_MAIN_EN_SET;
  assign wr_en_clr  = wr && addr == irqmp_pkg::OFS_MAIN_EN_CLR;
  assign wr_gen_set = wr && addr == irqmp_pkg::OFS_GRP_EN_SET;
  assign wr_gen_clr = wr && addr == irqmp_pkg::OFS_GRP_EN_CLR;
  assign wr_prio    = wr && prio_hit(addr);
  assign main_clr   = (wr && addr == irqmp_pkg::OFS_EDGE_CLR) ? wdata : 32'h0;
  assign grp_clr    = (wr && addr == irqmp_pkg::OFS_GRP_EDGE_CLR) ? wdata[7:0] : 8'h00;

  // ==========================================================================
  // Source sampling and status.
  // ==========================================================================
  logic [31:0] src;
  logic [31:0] act;
  logic [7:0]  gact;
  logic [31:0] unm;
  logic [7:0]  gunm;
  logic [31:0] msk;
  logic [7:0]  gmsk;

  // Software request is ORed onto source one; active level follows polarity.
  assign src  = src_request_lines | (32'(soft_q) << irqmp_pkg::SOFT_REQ_BIT);
  assign act  = ~(src ^ pol_q);
  assign gact = ~(group_request_inputs ^ gpol_q);
  // Level mode shows the live source, edge mode shows the latch.
  assign unm  = (mode_q & lat_q) | (~mode_q & act);
  assign gunm = (gmode_q & glat_q) | (~gmode_q & gact);
  // Masked views are pure gates, so they fall the moment unmasked bits do.
  assign msk  = unm & en_q;
  assign gmsk = gunm & gen_q;

  // Edge latch: an edge in the clearing cycle still sets, so none is lost.
  always_comb begin
    lat_d  = (lat_q & ~(main_clr & mode_q)) | (act & ~prev_q & mode_q);
    glat_d = (glat_q & ~(grp_clr & gmode_q)) | (gact & ~gprev_q & gmode_q);
  end

  // Previous active levels start high, so reset never fakes an edge.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q  <= 32'hffff_ffff;
      gprev_q <= 8'hff;
      lat_q   <= 32'h0;
      glat_q  <= 8'h00;
    end else begin
      prev_q  <= act;
      gprev_q <= gact;
      lat_q   <= lat_d;
      glat_q  <= glat_d;
    end
  end

  // ==========================================================================
  // Enables.
  // ==========================================================================
  // A simultaneous set and clear cannot happen: they live at different offsets.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_q  <= 32'h0;
      gen_q <= 8'h00;
    end else begin
      if (wr_en_set) begin
        en_q <= en_q | wdata;
      end else if (wr_en_clr) begin
        en_q <= en_q & ~wdata;
      end
      if (wr_gen_set) begin
        gen_q <= gen_q | wdata[7:0];
      end else if (wr_gen_clr) begin
        gen_q <= gen_q & ~wdata[7:0];
      end
    end
  end

  // ==========================================================================
  // Trigger configuration, software request and threshold.
  // ==========================================================================
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q  <= 32'h0;
      pol_q   <= irqmp_pkg::RST_MAIN_POL;
      gmode_q <= 8'h00;
      gpol_q  <= irqmp_pkg::RST_GRP_POL;
      soft_q  <= 1'b0;
      thr_q   <= irqmp_pkg::RST_THRESHOLD;
    end else if (wr) begin
      case (addr)
        irqmp_pkg::OFS_TRIG_MODE:     mode_q  <= wdata;
        irqmp_pkg::OFS_TRIG_POL:      pol_q   <= wdata;
        irqmp_pkg::OFS_GRP_TRIG_MODE: gmode_q <= wdata[7:0];
        irqmp_pkg::OFS_GRP_TRIG_POL:  gpol_q  <= wdata[7:0];
        irqmp_pkg::OFS_SOFT_REQ:      soft_q  <= wdata[irqmp_pkg::SOFT_REQ_BIT];
        irqmp_pkg::OFS_THRESHOLD:     thr_q   <= wdata[3:0];
        default: begin
        end
      endcase
    end
  end

  // ==========================================================================
  // Priorities.
  // ==========================================================================
  irqmp_prio_mem u_prio (
    .clk    (clk),
    .rst_n  (rst_n),
    .we     (wr_prio),
    .idx    (addr[3:2]),
    .wdata  (wdata),
    .fields (prio_f)
  );

  // ==========================================================================
  // Arbitration and core request.
  // ==========================================================================
  logic [31:0] thr_pass;
  logic        irq_d;

  always_comb begin
    for (int i = 0; i < irqmp_pkg::NUM_SRC; i++) begin
      thr_pass[i] = msk[i] && above_thr(prio_f[i*2 +: 2], thr_q);
    end
    irq_d = (|thr_pass) || (|gmsk);
  end

  // Readout and request are registered, so they lag level sources by one clock and edge sources by two.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reqnum_q <= irqmp_pkg::RST_REQ_NUM;
      core_irq <= 1'b0;
    end else begin
      reqnum_q <= pick(msk, prio_f);
      core_irq <= irq_d;
    end
  end

  // ==========================================================================
  // Read port.
  // ==========================================================================
  logic [31:0] rd_d;
  logic [31:0] prio_word;

  // Re-expand the selected priority word into nibble spacing.
  always_comb begin
    prio_word = 32'h0;
    for (int k = 0; k < irqmp_pkg::PRIO_PER_REG; k++) begin
      prio_word[k*irqmp_pkg::PRIO_NIBBLE +: irqmp_pkg::PRIO_W] = prio_f[addr[3:2]*16 + k*2 +: 2];
    end
  end

  // Write-only and unmapped offsets read as zero; reserved bits are zero.
  always_comb begin
    case (addr)
      irqmp_pkg::OFS_MAIN_STATUS:   rd_d = msk;
      irqmp_pkg::OFS_MAIN_UNMASKED: rd_d = unm;
      irqmp_pkg::OFS_MAIN_EN_SET:   rd_d = en_q;
      irqmp_pkg::OFS_GRP_STATUS:    rd_d = {24'h0, gmsk};
      irqmp_pkg::OFS_GRP_UNMASKED:  rd_d = {24'h0, gunm};
      irqmp_pkg::OFS_GRP_EN_SET:    rd_d = {24'h0, gen_q};
      irqmp_pkg::OFS_REQ_NUMBER:    rd_d = {16'h0, reqnum_q};
      irqmp_pkg::OFS_THRESHOLD:     rd_d = {28'h0, thr_q};
      irqmp_pkg::OFS_TRIG_MODE:     rd_d = mode_q;
      irqmp_pkg::OFS_TRIG_POL:      rd_d = pol_q;
      irqmp_pkg::OFS_GRP_TRIG_MODE: rd_d = {24'h0, gmode_q};
      irqmp_pkg::OFS_GRP_TRIG_POL:  rd_d = {24'h0, gpol_q};
      default:                      rd_d = prio_hit(addr) ? prio_word : 32'h0;
    endcase
  end

  // Data stand for exactly the cycle after the strobe, zero otherwise.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 32'h0;
    end else begin
      rdata <= rd ? rd_d : 32'h0;
    end
  end

  // ==========================================================================
  // Checks.
  // ==========================================================================
  sequence s_soft_raise;
    wr && addr == irqmp_pkg::OFS_SOFT_REQ && wdata[1] && !mode_q[1] && pol_q[1];
  endsequence

  sequence s_thr_write;
    wr && addr == irqmp_pkg::OFS_THRESHOLD;
  endsequence

  a_grp_masked_gate: assert property (@(posedge clk) disable iff (!rst_n)
    (gmsk & ~gen_q) == 8'h00) else $error("group masked bit set while disabled");

  a_edge_latch_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (glat_q[3] && gmode_q[3] && grp_clr[3] == 1'b0 && !(wr && addr == irqmp_pkg::OFS_GRP_TRIG_MODE))
    |=> glat_q[3]) else $error("group edge latch lost without clear");

  a_enable_set_bits: assert property (@(posedge clk) disable iff (!rst_n)
    wr_en_set |=> ((en_q & $past(wdata)) == $past(wdata)) && ((en_q & $past(en_q)) == $past(en_q)))
    else $error("enable set write wrong");

  a_enable_clr_bits: assert property (@(posedge clk) disable iff (!rst_n)
    wr_en_clr |=> en_q == ($past(en_q) & ~$past(wdata))) else $error("enable clear write wrong");

  a_thr_sw_only: assert property (@(posedge clk) disable iff (!rst_n)
    !(wr && addr == irqmp_pkg::OFS_THRESHOLD) |=> $stable(thr_q)) else $error("threshold moved without write");

  // The written nibble must be what the threshold holds one edge later.
  a_thr_sw_write: assert property (@(posedge clk) disable iff (!rst_n)
    s_thr_write |=> thr_q == $past(wdata[3:0])) else $error("threshold write not taken");

  a_reqnum_none: assert property (@(posedge clk) disable iff (!rst_n)
    msk == 32'h0 |=> reqnum_q == irqmp_pkg::RST_REQ_NUM) else $error("readout not 0xffff when idle");

  a_irq_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    (thr_q == 4'h3 && gmsk == 8'h00) |=> !core_irq) else $error("request above top threshold");

  a_soft_request: assert property (@(posedge clk) disable iff (!rst_n)
    s_soft_raise ##1 (!mode_q[1] && pol_q[1]) |-> unm[1]) else $error("software request not seen");

  a_level_follow: assert property (@(posedge clk) disable iff (!rst_n)
    !mode_q[2] && $changed(act[2]) |-> unm[2] == act[2]) else $error("level status not following");

  a_read_unmapped: assert property (@(posedge clk) disable iff (!rst_n)
    rd && !mapped(addr) |=> rdata == 32'h0) else $error("unmapped read not zero");

endmodule

/* verif/irqmp_src_model.sv */
`timescale 1ns/1ps

// ==========================================================================
// Request sources: peripheral units that hold a flag until their owner clears it.
// ==========================================================================
module irqmp_src_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [31:0] set_main,
  input  wire logic [31:0] clr_main,
  input  wire logic [31:0] inv_main,
  input  wire logic [7:0]  set_grp,
  input  wire logic [7:0]  clr_grp,
  output logic      [31:0] src_request_lines,
  output logic      [7:0]  group_request_inputs
);
  logic [31:0] main_flag_q;
  logic [7:0]  grp_flag_q;

  // A unit flag stays up until cleared, so a level request never drops by itself.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      main_flag_q <= 32'h0000_0000;
      grp_flag_q  <= 8'h00;
    end else begin
      main_flag_q <= (main_flag_q | set_main) & ~clr_main;
      grp_flag_q  <= (grp_flag_q | set_grp) & ~clr_grp;
    end
  end

  // Low-active units idle high, so the flag is shown through the chosen sense.
  assign src_request_lines    = main_flag_q ^ inv_main;
  assign group_request_inputs = grp_flag_q;
endmodule

/* verif/irqmp_ctrl_bench.sv */
`timescale 1ns/1ps

// ==========================================================================
// Bench for the interrupt controller.
// ==========================================================================
module irqmp_ctrl_bench;
  logic        clk;
  logic        rst_n;
  logic [11:0] addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic        core_irq;
  logic [31:0] src_request_lines;
  logic [7:0]  group_request_inputs;
  logic [31:0] set_main, clr_main, inv_main;
  logic [7:0]  set_grp, clr_grp;
  int          fail_count;
  int          n_compared;
  int          cycles;

  irqmp_ctrl dut_u (
    .clk                  (clk),
    .rst_n                (rst_n),
    .addr                 (addr),
    .wdata                (wdata),
    .wr                   (wr),
    .rd                   (rd),
    .rdata                (rdata),
    .src_request_lines    (src_request_lines),
    .group_request_inputs (group_request_inputs),
    .core_irq             (core_irq)
  );

  irqmp_src_model src_u (
    .clk                  (clk),
    .rst_n                (rst_n),
    .set_main             (set_main),
    .clr_main             (clr_main),
    .inv_main             (inv_main),
    .set_grp              (set_grp),
    .clr_grp              (clr_grp),
    .src_request_lines    (src_request_lines),
    .group_request_inputs (group_request_inputs)
  );

  // 25 MHz clock.
  always #20 clk = ~clk;

  // Hang guard: the whole run needs under two hundred cycles, so 4000 is generous.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      fail_count = fail_count + 1;
      end_sim();
    end
  end

  // ========================================================================
  // Compare, bus and stimulus tasks.
  // ========================================================================
  task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample just past that edge.
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk32($sformatf("reg %h", a), exp, rdata);
  endtask

  // Raise or clear unit flags for one cycle of commands.
  task automatic src(input logic [31:0] sm, input logic [31:0] cm, input logic [7:0] sg, input logic [7:0] cg);
    @(posedge clk);
    set_main <= sm;
    clr_main <= cm;
    set_grp  <= sg;
    clr_grp  <= cg;
    @(posedge clk);
    set_main <= 32'h0000_0000;
    clr_main <= 32'h0000_0000;
    set_grp  <= 8'h00;
    clr_grp  <= 8'h00;
  endtask

  // The core request follows a status change by one edge; two give margin.
  task automatic chk_irq(input logic exp);
    repeat (2) @(posedge clk);
    #1;
    chk1("core_irq", exp, core_irq);
  endtask

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ========================================================================
  // Main sequence.
  // ========================================================================
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    addr = 12'h000;
    wdata = 32'h0000_0000;
    wr = 1'b0;
    rd = 1'b0;
    {set_main, clr_main, inv_main} = '0;
    {set_grp, clr_grp} = '0;
    fail_count = 0;
    n_compared = 0;
    cycles = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(12'h008, 32'h0000_0000);
    rd_chk(12'h028, 32'h0000_0000);
    rd_chk(12'h084, 32'hffff_ffff);
    rd_chk(12'h080, 32'h0000_0000);
    rd_chk(12'h054, 32'h0000_000f);
    rd_chk(12'h050, 32'h0000_ffff);
    rd_chk(12'h02c, 32'h0000_0000);
    rd_chk(12'h0fc, 32'h0000_0000);
    chk_irq(1'b0);
    $display("test reset done");
    src(32'h0, 32'h0, 8'h08, 8'h00);
    rd_chk(12'h024, 32'h0000_0008);
    rd_chk(12'h020, 32'h0000_0000);
    chk_irq(1'b0);
    wr_reg(12'h028, 32'h0000_0008);
    wr_reg(12'h028, 32'h0000_0000);
    rd_chk(12'h028, 32'h0000_0008);
    rd_chk(12'h020, 32'h0000_0008);
    chk_irq(1'b1);
    wr_reg(12'h02c, 32'h0000_0000);
    rd_chk(12'h028, 32'h0000_0008);
    wr_reg(12'h02c, 32'h0000_0008);
    rd_chk(12'h028, 32'h0000_0000);
    chk_irq(1'b0);
    wr_reg(12'h028, 32'h0000_0008);
    src(32'h0, 32'h0, 8'h00, 8'h08);
    rd_chk(12'h024, 32'h0000_0000);
    rd_chk(12'h020, 32'h0000_0000);
    $display("test group level done");
    wr_reg(12'h0a0, 32'h0000_0008);
    src(32'h0, 32'h0, 8'h08, 8'h00);
    src(32'h0, 32'h0, 8'h00, 8'h08);
    rd_chk(12'h024, 32'h0000_0008);
    rd_chk(12'h020, 32'h0000_0008);
    wr_reg(12'h0a8, 32'h0000_0000);
    rd_chk(12'h024, 32'h0000_0008);
    wr_reg(12'h0a8, 32'h0000_0008);
    rd_chk(12'h024, 32'h0000_0000);
    rd_chk(12'h020, 32'h0000_0000);
    chk_irq(1'b0);
    wr_reg(12'h02c, 32'h0000_0008);
    $display("test group edge done");
    wr_reg(12'h040, 32'h0030_0100);
    wr_reg(12'h044, 32'h0000_0030);
    rd_chk(12'h040, 32'h0030_0100);
    rd_chk(12'h044, 32'h0000_0030);
    wr_reg(12'h008, 32'h0000_0224);
    src(32'h0000_0224, 32'h0, 8'h00, 8'h00);
    rd_chk(12'h050, 32'h0000_0305);
    rd_chk(12'h000, 32'h0000_0224);
    chk_irq(1'b1);
    wr_reg(12'h054, 32'h0000_0003);
    chk_irq(1'b0);
    rd_chk(12'h050, 32'h0000_0305);
    wr_reg(12'h054, 32'h0000_0002);
    chk_irq(1'b1);
    src(32'h0, 32'h0000_0220, 8'h00, 8'h00);
    rd_chk(12'h050, 32'h0000_0102);
    chk_irq(1'b0);
    rd_chk(12'h054, 32'h0000_0002);
    wr_reg(12'h054, 32'h0000_000f);
    chk_irq(1'b1);
    wr_reg(12'h054, 32'h0000_0000);
    chk_irq(1'b1);
    src(32'h0, 32'h0000_0004, 8'h00, 8'h00);
    rd_chk(12'h050, 32'h0000_ffff);
    chk_irq(1'b0);
    $display("test priority done");
    wr_reg(12'h010, 32'h0000_0002);
    rd_chk(12'h004, 32'h0000_0002);
    wr_reg(12'h010, 32'h0000_0000);
    rd_chk(12'h004, 32'h0000_0000);
    $display("test software request done");
    @(posedge clk);
    inv_main <= 32'h0000_0080;
    // Card-detect users clear polarity bit 28 themselves; source 7 is made falling-edge.
    wr_reg(12'h084, 32'hefff_ff7f);
    rd_chk(12'h084, 32'hefff_ff7f);
    wr_reg(12'h080, 32'h0000_0080);
    rd_chk(12'h004, 32'h1000_0000);
    src(32'h0000_0080, 32'h0, 8'h00, 8'h00);
    src(32'h0, 32'h0000_0080, 8'h00, 8'h00);
    rd_chk(12'h004, 32'h1000_0080);
    wr_reg(12'h088, 32'h0000_0000);
    rd_chk(12'h004, 32'h1000_0080);
    wr_reg(12'h088, 32'h1000_0080);
    rd_chk(12'h004, 32'h1000_0000);
    $display("test main edge done");
    wr_reg(12'h00c, 32'h0000_0024);
    rd_chk(12'h008, 32'h0000_0200);
    wr_reg(12'h028, 32'hffff_ffff);
    rd_chk(12'h028, 32'h0000_00ff);
    wr_reg(12'h02c, 32'hffff_ffff);
    rd_chk(12'h028, 32'h0000_0000);
    rd_chk(12'h0a0, 32'h0000_0008);
    rd_chk(12'h0a4, 32'h0000_00ff);
    $display("test enable registers done");
    end_sim();
  end
endmodule
